// ==== core/oamfp_top.sv ====
`timescale 1ns/10ps

// Receive buffer between MAC and parser; flags kept as flops
module oamfp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Synchronised reset
   input wire logic in_valid, // Write request
   input wire logic [WIDTH-1:0] in_data, // Write word
   output logic in_ready, // Room for a word
   output logic out_valid, // Word available
   output logic [WIDTH-1:0] out_data, // Oldest word
   input wire logic out_ready // Read request
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW-1:0] wr_ptr; // Next write slot
   logic [AW-1:0] rd_ptr; // Next read slot
   logic [AW:0] count; // Words held
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_data = mem[rd_ptr];

   // Storage has no reset; only pointers, count and flags need a known value
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and registered full/empty
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr <= push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
         rd_ptr <= pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
         count <= next_count;
         in_ready <= next_count < (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end
endmodule

module oamfp_top
   import oamfp_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic rst_b, // Asynchronous reset, active low
   // Received frames from the MAC
   input wire logic mac_rx_valid, // Octet valid
   input wire logic [7:0] mac_rx_data, // Octet
   input wire logic mac_rx_last, // Final octet of frame
   output logic mac_rx_ready, // Buffer can take an octet
   input wire oamfp_par_action_t par_action, // Non-OAM frame handling
   // Parsed frames out, shared data lanes
   output logic client_rx_indication, // Octet for the client above
   output logic loopback_tx_request, // Octet for the multiplexer loopback
   output logic control_rx_indication, // Octet of an oam_frame for control
   output logic [7:0] rx_out_data, // Octet
   output logic rx_out_last, // Final octet
   input wire logic rx_out_ready, // Consumer takes the octet
   output logic link_timer_restart, // Lost-link timer restart pulse
   output logic [1:0] peer_disc, // Last valid peer discovery bits
   // Frame build request
   input wire logic tx_req, // Start a frame, pulse
   input wire logic tx_info, // Information frame built here
   input wire logic [7:0] tx_code, // Client code, other frames
   input wire logic tx_no_data, // No data octets, pad only
   input wire logic [47:0] port_mac, // This port's address
   input wire logic remote_state_valid, // Peer information valid
   input wire logic [1:0] local_disc, // Local discovery status
   input wire logic crit_event, // Critical event flag
   input wire logic dying_gasp, // Unrecoverable local failure
   input wire logic link_fault, // Local receive fault
   input wire logic txd_valid, // Client data octet valid
   input wire logic [7:0] txd_data, // Client data octet
   input wire logic txd_last, // Final client data octet
   output logic txd_ready, // Data octet taken
   output logic tx_busy, // Frame in progress
   output logic tx_refused, // Reserved code refused, pulse
   // Built frames to the MAC
   output logic mac_tx_valid, // Octet valid
   output logic [7:0] mac_tx_data, // Octet
   output logic mac_tx_last, // Final octet before FCS
   input wire logic mac_tx_ready // MAC takes the octet
);
   // Reset: asserted at once, released after two edges
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   default clocking dflt @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Octet of a 48-bit address, first transmitted octet at the top
   function automatic logic [7:0] addr_octet(input logic [47:0] a, input int k);
      return a[8*(5-k) +: 8];
   endfunction

   // ---------------- Receive side ----------------
   typedef enum logic [1:0] {P_HDR, P_REPLAY, P_BODY, P_DROP} oamfp_pstate_t;
   oamfp_pstate_t p_state; // Parser state; P_HDR with nothing held is idle
   logic f_valid; // Buffered octet present
   logic [8:0] f_word; // {last, octet}
   logic f_pop; // Parser takes an octet
   logic [7:0] hdr [CLASSIFY_OCTETS]; // Held leading octets
   logic [3:0] hcnt; // Octets held
   logic [3:0] rcnt; // Replay index
   logic ended; // Frame ended within the held octets
   logic is_oam; // Current frame is an oam_frame
   logic [1:0] dest; // 0 client, 1 loopback, 2 control
   logic [4:0] body_pos; // Octet position, saturates
   logic [1:0] rem_disc; // Peer's last valid stable/evaluating

   // Backpressure from the parser reaches the MAC through the buffer
   oamfp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(mac_rx_valid),
      .in_data({mac_rx_last, mac_rx_data}),
      .in_ready(mac_rx_ready),
      .out_valid(f_valid),
      .out_data(f_word),
      .out_ready(f_pop)
   );

   wire f_last = f_word[8];
   wire [7:0] f_byte = f_word[7:0];
   wire rx_any = client_rx_indication || loopback_tx_request || control_rx_indication;
   wire can_emit = !rx_any || rx_out_ready;
   // Classification needs type and subtype both
   wire cls_now = p_state == P_HDR && f_valid && (f_last || hcnt == 4'(SUBTYPE_POS));
   wire type_hit = {hdr[TYPE_POS], hdr[TYPE_POS+1]} == SLOW_PROTO_TYPE;
   wire oam_hit = hcnt == 4'(SUBTYPE_POS) && type_hit && f_byte == OAM_SUBTYPE;
   wire drop_now = !oam_hit && par_action != forward_mode && par_action != loopback_mode;
   wire [1:0] cls_dest = oam_hit ? 2'h2 : (par_action == loopback_mode ? 2'h1 : 2'h0);
   wire replay_emit = p_state == P_REPLAY && can_emit;
   wire replay_end = replay_emit && rcnt == hcnt - 4'h1;
   wire body_emit = p_state == P_BODY && f_valid && can_emit;
   assign f_pop = (p_state == P_HDR || p_state == P_DROP) ? f_valid : body_emit;
   wire emit = replay_emit || body_emit;
   wire [7:0] emit_byte = replay_emit ? hdr[rcnt] : f_byte;
   wire emit_last = replay_emit ? (ended && replay_end) : f_last;
   wire rx_done = rx_any && rx_out_ready && rx_out_last;
   // Second flags octet of a received oam_frame; 0x3 in 4:3 is ignored
   wire flag_cap = body_emit && dest == 2'h2 && body_pos == 5'(FLAGS_POS + 1);
   wire disc_ok = f_byte[FLG_DISC_LSB +: 2] != DISC_RSVD;

   // Hold the leading octets
   always_ff @(posedge sys_clk) begin
      if (p_state == P_HDR && f_valid) begin
         hdr[hcnt] <= f_byte;
      end
   end

   // Parser sequence; action is sampled once per frame at classification
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         p_state <= P_HDR;
         hcnt <= '0;
         rcnt <= '0;
         ended <= 1'b0;
         is_oam <= 1'b0;
         dest <= 2'h0;
      end else begin
         unique case (p_state)
            P_HDR: begin
               if (cls_now) begin
                  is_oam <= oam_hit;
                  dest <= cls_dest;
                  ended <= f_last;
                  rcnt <= '0;
                  hcnt <= hcnt + 4'h1;
                  if (drop_now) begin
                     p_state <= f_last ? P_HDR : P_DROP;
                     hcnt <= '0;
                  end else begin
                     p_state <= P_REPLAY;
                  end
               end else if (f_valid) begin
                  hcnt <= hcnt + 4'h1;
               end
            end
            P_REPLAY: begin
               if (replay_emit) begin
                  rcnt <= rcnt + 4'h1;
               end
               if (replay_end) begin
                  p_state <= ended ? P_HDR : P_BODY;
                  hcnt <= '0;
               end
            end
            P_BODY: begin
               if (body_emit && f_last) begin
                  p_state <= P_HDR; // Back to idle after handing on
               end
            end
            P_DROP: begin
               if (f_valid && f_last) begin
                  p_state <= P_HDR;
               end
            end
         endcase
      end
   end

   // Body position and peer flag capture
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         body_pos <= 5'(CLASSIFY_OCTETS);
         rem_disc <= 2'h0;
      end else begin
         if (p_state != P_BODY) begin
            body_pos <= 5'(CLASSIFY_OCTETS);
         end else if (body_emit && body_pos != 5'h1F) begin
            body_pos <= body_pos + 5'h1;
         end
         if (flag_cap && disc_ok) begin
            rem_disc <= f_byte[FLG_DISC_LSB +: 2];
         end
      end
   end

   // Output octet register; one valid per destination
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         client_rx_indication <= 1'b0;
         loopback_tx_request <= 1'b0;
         control_rx_indication <= 1'b0;
         rx_out_data <= 8'h00;
         rx_out_last <= 1'b0;
         link_timer_restart <= 1'b0;
         peer_disc <= 2'h0;
      end else begin
         if (emit) begin
            client_rx_indication <= dest == 2'h0;
            loopback_tx_request <= dest == 2'h1;
            control_rx_indication <= dest == 2'h2;
            rx_out_data <= emit_byte;
            rx_out_last <= emit_last;
         end else if (rx_out_ready) begin
            client_rx_indication <= 1'b0;
            loopback_tx_request <= 1'b0;
            control_rx_indication <= 1'b0;
         end
         // Restart once the whole oam_frame has been handed on
         link_timer_restart <= rx_done && control_rx_indication;
         peer_disc <= rem_disc;
      end
   end

   // ---------------- Transmit side ----------------
   typedef enum logic [1:0] {T_IDLE, T_HDR, T_DATA, T_PAD} oamfp_tstate_t;
   oamfp_tstate_t t_state; // Builder state
   logic [10:0] t_pos; // Octet being produced
   logic [7:0] t_code; // Latched code
   logic [7:0] t_flags; // Latched low flags octet
   logic t_nodata; // Latched pad-only request
   // Untagged basic frame: type follows SA directly
   wire [1:0] tx_disc = local_disc == DISC_RSVD ? DISC_PENDING : local_disc;
   wire [1:0] rem_bits = remote_state_valid ? rem_disc : 2'h0;
   wire [7:0] flags_lo = {1'b0, rem_bits, tx_disc[1:0], crit_event, dying_gasp, link_fault};
   wire req_code_bad = !tx_info && oamfp_code_reserved(tx_code);
   wire t_can = !mac_tx_valid || mac_tx_ready;
   wire take_d = txd_ready && txd_valid;
   wire hdr_emit = t_state == T_HDR && t_can;
   wire pad_emit = t_state == T_PAD && t_can;
   wire t_emit = hdr_emit || pad_emit || take_d;
   wire body_short = t_pos < 11'(MIN_BODY_OCTETS - 1);
   wire t_last = (pad_emit && !body_short) || (take_d && txd_last && !body_short);
   wire t_stay = mac_tx_valid && !mac_tx_ready;
   // Header octet at the current position, fields in wire order
   logic [7:0] hdr_octet;
   always_comb begin
      hdr_octet = 8'h00;
      if (t_pos < 11'(SA_POS)) begin
         hdr_octet = addr_octet(SLOW_PROTO_DA, int'(t_pos));
      end else if (t_pos < 11'(TYPE_POS)) begin
         hdr_octet = addr_octet(port_mac, int'(t_pos) - SA_POS);
      end else if (t_pos == 11'(TYPE_POS)) begin
         hdr_octet = SLOW_PROTO_TYPE[15:8];
      end else if (t_pos == 11'(TYPE_POS + 1)) begin
         hdr_octet = SLOW_PROTO_TYPE[7:0];
      end else if (t_pos == 11'(SUBTYPE_POS)) begin
         hdr_octet = OAM_SUBTYPE;
      end else if (t_pos == 11'(FLAGS_POS + 1)) begin
         hdr_octet = t_flags;
      end else if (t_pos == 11'(CODE_POS)) begin
         hdr_octet = t_code;
      end
   end
   wire [7:0] t_byte = hdr_emit ? hdr_octet : (take_d ? txd_data : 8'h00);
   wire next_tx_valid = t_emit || t_stay;
   oamfp_tstate_t t_next;
   always_comb begin
      t_next = t_state;
      unique case (t_state)
         T_IDLE: t_next = (tx_req && !req_code_bad) ? T_HDR : T_IDLE;
         T_HDR: begin
            if (hdr_emit && t_pos == 11'(HDR_OCTETS - 1)) begin
               t_next = t_nodata ? T_PAD : T_DATA;
            end
         end
         T_DATA: begin
            if (take_d && txd_last) begin
               t_next = body_short ? T_PAD : T_IDLE;
            end
         end
         T_PAD: t_next = (pad_emit && !body_short) ? T_IDLE : T_PAD;
      endcase
   end

   // Builder sequence and request latching; flags frozen per frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         t_state <= T_IDLE;
         t_pos <= '0;
         t_code <= CODE_INFO;
         t_flags <= 8'h00;
         t_nodata <= 1'b0;
         tx_refused <= 1'b0;
         tx_busy <= 1'b0;
      end else begin
         t_state <= t_next;
         tx_busy <= t_next != T_IDLE;
         tx_refused <= t_state == T_IDLE && tx_req && req_code_bad;
         if (t_state == T_IDLE && tx_req) begin
            t_code <= tx_info ? CODE_INFO : tx_code;
            t_flags <= flags_lo;
            t_nodata <= tx_no_data;
            t_pos <= '0;
         end else if (t_emit) begin
            t_pos <= t_pos + 11'h1;
         end
      end
   end

   // MAC-facing octet register; data side takes one octet per free slot
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mac_tx_valid <= 1'b0;
         mac_tx_data <= 8'h00;
         mac_tx_last <= 1'b0;
         txd_ready <= 1'b0;
      end else begin
         mac_tx_valid <= next_tx_valid;
         if (t_emit) begin
            mac_tx_data <= t_byte;
            mac_tx_last <= t_last;
         end
         txd_ready <= t_next == T_DATA && !next_tx_valid;
      end
   end

   // ---------------- Checks ----------------
   logic [10:0] tx_idx; // Octets accepted by the MAC in this frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_idx <= '0;
      end else if (mac_tx_valid && mac_tx_ready) begin
         tx_idx <= mac_tx_last ? 11'h0 : tx_idx + 11'h1;
      end
   end
   wire tx_at_flags = mac_tx_valid && tx_idx == 11'(FLAGS_POS + 1);

   sequence refused_req_s;
      t_state == T_IDLE && tx_req && !tx_info && oamfp_code_reserved(tx_code);
   endsequence
   sequence stays_idle_s;
      tx_refused && t_state == T_IDLE ##1 !tx_busy;
   endsequence

   drop_silent_a: assert property (p_state == P_DROP |=> !$rose(rx_any))
      else $error("output produced while dropping a frame");
   // Only while a non-final octet is held is the parser still on that frame
   fwd_route_a: assert property (client_rx_indication && !rx_out_last
      |-> !is_oam && dest == 2'h0)
      else $error("client octet not from a forwarded frame");
   loop_route_a: assert property ($rose(loopback_tx_request) |-> !is_oam)
      else $error("loopback octet from an OAM frame");
   timer_restart_a: assert property (rx_done && control_rx_indication |=> link_timer_restart)
      else $error("lost-link timer not restarted");
   oam_class_a: assert property (cls_now && oam_hit |=> is_oam && dest == 2'h2)
      else $error("matching frame not classified as OAM");
   subtype_out_a: assert property (mac_tx_valid && tx_idx == 11'(SUBTYPE_POS)
      |-> mac_tx_data == OAM_SUBTYPE)
      else $error("wrong subtype octet");
   type_out_a: assert property (mac_tx_valid && tx_idx == 11'(TYPE_POS)
      |-> mac_tx_data == SLOW_PROTO_TYPE[15:8])
      else $error("wrong type octet");
   flags_rsvd_a: assert property ((mac_tx_valid && tx_idx == 11'(FLAGS_POS)
      |-> mac_tx_data == 8'h00) and (tx_at_flags |-> !mac_tx_data[7]))
      else $error("reserved flag bits not zero");
   disc_code_a: assert property (tx_at_flags
      |-> mac_tx_data[FLG_DISC_LSB +: 2] != DISC_RSVD)
      else $error("discovery value 3 transmitted");
   min_len_a: assert property (mac_tx_valid && mac_tx_last
      |-> tx_idx >= 11'(MIN_BODY_OCTETS - 1))
      else $error("frame shorter than minimum");
   refuse_code_a: assert property (refused_req_s |=> stays_idle_s)
      else $error("reserved code not refused");
endmodule

// ==== core/oamfp_pkg.sv ====
package oamfp_pkg;
   // Frame identification values
   localparam logic [47:0] SLOW_PROTO_DA = 48'h0180C2000002; // Slow-protocols group address
   localparam logic [15:0] SLOW_PROTO_TYPE = 16'h8809; // Slow-protocols ethertype
   localparam logic [7:0] OAM_SUBTYPE = 8'h03; // Marks the frame as OAM
   // Octet positions inside a frame (first octet on the wire is 0)
   localparam int DA_POS = 0;
   localparam int SA_POS = 6;
   localparam int TYPE_POS = 12;
   localparam int SUBTYPE_POS = 14;
   localparam int FLAGS_POS = 15; // Flags bits 15:8, then 7:0
   localparam int CODE_POS = 17;
   localparam int HDR_OCTETS = 18; // Everything before the data field
   localparam int CLASSIFY_OCTETS = 15; // Octets needed to tell OAM from other
   // Minimum frame, FCS appended by the MAC below
   localparam int MIN_FRAME_OCTETS = 64;
   localparam int FCS_OCTETS = 4;
   localparam int MIN_BODY_OCTETS = MIN_FRAME_OCTETS - FCS_OCTETS;
   // Bit positions in the low flags octet
   localparam int FLG_REM_STABLE = 6;
   localparam int FLG_REM_EVAL = 5;
   localparam int FLG_DISC_LSB = 3;
   localparam int FLG_CRIT = 2;
   localparam int FLG_DYING = 1;
   localparam int FLG_LFAULT = 0;
   // Local discovery status encodings
   localparam logic [1:0] DISC_UNSAT = 2'h0;
   localparam logic [1:0] DISC_PENDING = 2'h1;
   localparam logic [1:0] DISC_DONE = 2'h2;
   localparam logic [1:0] DISC_RSVD = 2'h3;
   // Code field values
   localparam logic [7:0] CODE_INFO = 8'h00;
   localparam logic [7:0] CODE_EVENT = 8'h01;
   localparam logic [7:0] CODE_VAR_REQ = 8'h02;
   localparam logic [7:0] CODE_VAR_RESP = 8'h03;
   localparam logic [7:0] CODE_LB_CTL = 8'h04;
   localparam logic [7:0] CODE_ORG = 8'hFE;
   // Action on received frames that are not OAM
   typedef enum logic [1:0] {forward_mode, loopback_mode, discard_mode} oamfp_par_action_t;
   // Reserved codes: 05..FD and FF
   function automatic logic oamfp_code_reserved(input logic [7:0] code);
      return (code > CODE_LB_CTL && code < CODE_ORG) || code == 8'hFF;
   endfunction
endpackage

// ==== bench/oamfp_mac_model.sv ====
`timescale 1ns/10ps
// Far-side MAC model: takes built octets and stalls one cycle in three
module oamfp_mac_model (
   input wire logic sys_clk, // Clock
   input wire logic mac_tx_valid, // Octet offered
   input wire logic [7:0] mac_tx_data, // Octet
   input wire logic mac_tx_last, // Final octet
   input wire logic cap_clr, // Start a fresh capture
   output logic mac_tx_ready // Octet accepted
);
   logic [7:0] cap [0:127]; // Octets in wire order
   int n = 0; // Octets captured
   int last_at = -1; // Index of the final octet
   int ph = 0; // Stall phase
   // Stalls make the builder hold each octet until taken
   always @(negedge sys_clk) begin
      ph = (ph + 1) % 3;
   end
   assign mac_tx_ready = (ph != 0);
   // Capture on the edge where the octet is taken
   always @(posedge sys_clk) begin
      if (cap_clr) begin
         n = 0;
         last_at = -1;
      end else if (mac_tx_valid && mac_tx_ready && n < 128) begin
         cap[n] = mac_tx_data;
         if (mac_tx_last) last_at = n;
         n = n + 1;
      end
   end
endmodule

// ==== bench/oam_frame_parse_format_bench.sv ====
`timescale 1ns/10ps
module oam_frame_parse_format_bench;
   import oamfp_pkg::*;
   logic sys_clk = 0, rst_b = 0, mac_rx_valid = 0, mac_rx_last = 0, rx_out_ready = 1;
   logic [7:0] mac_rx_data = 0, tx_code = 0, txd_data = 0;
   oamfp_par_action_t par_action = forward_mode;
   logic tx_req = 0, tx_info = 0, tx_no_data = 1, remote_state_valid = 0, cap_clr = 0;
   logic crit_event = 0, dying_gasp = 0, link_fault = 0, txd_valid = 0, txd_last = 0;
   logic [1:0] local_disc = 0, peer_disc;
   logic [47:0] port_mac = 48'h02A1B2C3D4E5; // Individual address
   logic mac_rx_ready, client_rx_indication, loopback_tx_request, control_rx_indication;
   logic [7:0] rx_out_data, mac_tx_data;
   logic rx_out_last, link_timer_restart, txd_ready, tx_busy, tx_refused;
   logic mac_tx_valid, mac_tx_last, mac_tx_ready;
   int errors = 0, samples_checked = 0, rn = 0, nlt = 0, nref = 0, rl = 0, dsent = 3;
   logic [2:0] rk [0:127]; // Which output carried each octet
   logic [7:0] rd [0:127]; // Octets delivered upward
   logic [7:0] okc [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hFE};
   logic [7:0] rsv [3] = '{8'h05, 8'hFD, 8'hFF};
   wire [2:0] kd = {control_rx_indication, loopback_tx_request, client_rx_indication};
   oamfp_top dut (.*);
   oamfp_mac_model mac (.*);
   always #12.5 sys_clk = ~sys_clk;
   // Record what leaves the parser and the single-cycle pulses
   always @(posedge sys_clk) begin
      if (tx_refused === 1'b1) nref++;
      if (link_timer_restart === 1'b1) nlt++;
      if (rx_out_ready && kd != 3'b000 && rn < 128) begin
         rk[rn] = kd;
         rd[rn] = rx_out_data;
         if (rx_out_last) rl = rn;
         rn++;
      end
   end
   // Client data source: three octets per data frame, each held until taken
   always @(posedge sys_clk) begin
      if (tx_req && !tx_no_data) dsent <= 0;
      else if (txd_valid && txd_ready) dsent <= dsent + 1;
   end
   always @(negedge sys_clk) begin
      txd_valid = dsent < 3;
      txd_data = 8'(dsent + 8'hA0);
      txd_last = dsent == 2;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // Received octet i; subtype and low flags octet chosen per test
   function automatic logic [7:0] rxb(int i, logic [7:0] sub, logic [7:0] f);
      return i == 12 ? 8'h88 : i == 13 ? 8'h09 : i == 14 ? sub : i == 16 ? f : 8'(i + 32);
   endfunction
   function automatic logic [7:0] txb(int i, logic [7:0] fl, logic [7:0] cd);
      if (i < 6) return SLOW_PROTO_DA[47-8*i -: 8];
      if (i < 12) return port_mac[95-8*i -: 8];
      if (i < 14) return SLOW_PROTO_TYPE[111-8*i -: 8];
      if (i == 14) return OAM_SUBTYPE;
      if (i == 16) return fl;
      if (i == 17) return cd;
      if (!tx_no_data && i >= 18 && i < 21) return 8'(i - 18 + 8'hA0);
      return 8'h00; // High flags octet and pad
   endfunction
   // Send a 20-octet frame, holding each octet until it is taken
   task automatic rx_check(input logic [7:0] sub, f, input logic [2:0] kind, input int cnt);
      int b;
      b = rn;
      for (int i = 0; i < 20; i++) begin
         @(negedge sys_clk);
         mac_rx_valid = 1;
         mac_rx_data = rxb(i, sub, f);
         mac_rx_last = (i == 19);
         do @(posedge sys_clk); while (mac_rx_ready !== 1'b1);
      end
      @(negedge sys_clk);
      mac_rx_valid = 0;
      mac_rx_last = 0;
      repeat (40) @(negedge sys_clk);
      chk(8'(rn - b), 8'(cnt));
      if (cnt > 0) chk(8'(rl - b), 8'(cnt - 1));
      for (int i = 0; i < rn - b; i++) begin
         chk({5'h0, rk[b + i]} ^ {rd[b + i] ^ rxb(i, sub, f)}, {5'h0, kind});
      end
   endtask
   // Request a frame and wait for the builder to go idle
   task automatic tx_check(input logic info, input logic [7:0] code, fl, cd, input int len);
      int k;
      @(negedge sys_clk);
      cap_clr = 1;
      tx_info = info;
      tx_code = code;
      tx_req = 1;
      @(negedge sys_clk);
      tx_req = 0;
      cap_clr = 0;
      k = 0;
      while (tx_busy === 1'b1 && k < 300) begin
         @(negedge sys_clk);
         k++;
      end
      repeat (3) @(negedge sys_clk);
      chk(8'(mac.n), 8'(len));
      if (len > 0) chk(8'(mac.last_at), 8'h3B);
      for (int i = 0; i < len; i++) chk(mac.cap[i], txb(i, fl, cd));
   endtask
   task automatic final_report;
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      errors++;
      final_report;
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      rst_b = 1;
      repeat (4) @(negedge sys_clk);
      rx_check(8'h03, 8'h10, 3'b100, 20);
      chk(8'(nlt), 8'h01);
      chk({6'h0, peer_disc}, 8'h02);
      rx_check(8'h03, 8'h18, 3'b100, 20);
      chk({6'h0, peer_disc}, 8'h02);
      $display("test rx oam done");
      rx_check(8'h04, 8'h10, 3'b001, 20);
      par_action = loopback_mode;
      rx_check(8'h04, 8'h10, 3'b010, 20);
      par_action = discard_mode;
      rx_check(8'h04, 8'h10, 3'b000, 0);
      $display("test rx modes done");
      remote_state_valid = 1;
      local_disc = 2'h3;
      crit_event = 1;
      link_fault = 1;
      tx_check(1, 8'h55, 8'h4D, 8'h00, 60);
      remote_state_valid = 0;
      local_disc = 2'h2;
      crit_event = 0;
      link_fault = 0;
      dying_gasp = 1;
      for (int c = 0; c < 6; c++) tx_check(0, okc[c], 8'h12, okc[c], 60);
      tx_no_data = 0;
      tx_check(0, 8'h01, 8'h12, 8'h01, 60);
      tx_no_data = 1;
      $display("test tx frames done");
      for (int c = 0; c < 3; c++) tx_check(0, rsv[c], 8'h00, 8'h00, 0);
      chk(8'(nref), 8'h03);
      $display("test tx refusal done");
      final_report;
   end
endmodule
